/* File: rtl/can_rx_pkg.sv */
// constants and carrier types for the CAN receive buffer and filter register block
package can_rx_pkg;
	localparam int ADDR_LSB_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ID_HIGH = 8'h04;
	localparam logic [7:0] OFS_ID_LOW = 8'h08;
	localparam logic [7:0] OFS_EXT_HIGH = 8'h0C;
	localparam logic [7:0] OFS_EXT_LOW = 8'h10;
	localparam logic [7:0] OFS_LENGTH = 8'h14;
	localparam logic [7:0] OFS_DATA0 = 8'h18;
	localparam logic [7:0] OFS_DATA7 = 8'h34;
	localparam logic [7:0] OFS_REC = 8'h38;
	localparam logic [7:0] OFS_STATUS = 8'h3C;
	// filter/mask region: 0x40 filter 0, 0x50 filter 1, 0x60 mask; 4 words each
	localparam logic [1:0] ID_REGION = 2'h1;
	localparam int NUM_FILTERS = 2;
	localparam int NUM_ID_SETS = 3;
	localparam int MASK_IDX = 2;
	localparam int DATA_BYTES = 8;
	localparam logic [3:0] MAX_LENGTH = 4'h8;
	localparam int FULL_BIT = 7;
	localparam int COPY_BIT = 3;
	localparam int HIT_BIT = 0;
	localparam int SRR_BIT = 4;
	localparam int EXT_BIT = 3;
	localparam int RTR_BIT = 6;
	localparam int PASSIVE_BIT = 0;
	localparam logic [7:0] ID_LOW_WMASK = 8'hEB;
	localparam logic [7:0] FILTER_LOW_WMASK = 8'hEB;
	localparam logic [7:0] MASK_LOW_WMASK = 8'hE3;
	localparam logic [7:0] LENGTH_WMASK = 8'h4F;
	localparam logic [7:0] REC_PASSIVE_LIMIT = 8'h7F;
	localparam logic [7:0] REC_RESTORE = 8'h77;
	localparam logic [7:0] REC_MAX = 8'hFF;
	localparam logic [7:0] REC_STEP_SMALL = 8'h01;
	localparam logic [7:0] REC_STEP_LARGE = 8'h08;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam int HTRANS_ACTIVE_BIT = 1;

	typedef struct packed {
		logic valid;
		logic ext;
		logic rtr;
		logic [28:0] id;
		logic [3:0] length;
		logic [63:0] data;
	} rx_frame_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
		logic [7:0] ext_high;
		logic [7:0] ext_low;
	} id_set_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_COMMIT = 2'b10
	} rx_state_t;
endpackage

/* File: rtl/can_rx_regs.sv */
// CAN receive buffer, acceptance filters, mask and receive error counter behind AHB-Lite
`timescale 1ns/10ps
module can_rx_regs
	import can_rx_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire rx_frame_t rx_frame,
	input wire logic rx_err_small,
	input wire logic rx_err_large,
	input wire logic rx_ok,
	output logic error_passive,
	output logic buffer_full
);
	logic rd_pend_r, rd_pend_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic addr_phase;
	logic wr_en;
	logic [7:0] wbyte;

	rx_state_t state_r, state_nxt;
	logic full_r, full_nxt;
	logic copy_r, copy_nxt;
	logic hit_r, hit_nxt;
	logic [7:0] id_high_r, id_high_nxt;
	logic [7:0] id_low_r, id_low_nxt;
	logic [7:0] ext_high_r, ext_high_nxt;
	logic [7:0] ext_low_r, ext_low_nxt;
	logic [7:0] length_r, length_nxt;
	logic [7:0] data_r [DATA_BYTES];
	logic [7:0] data_nxt [DATA_BYTES];
	id_set_t sets_r [NUM_ID_SETS];
	id_set_t sets_nxt [NUM_ID_SETS];
	logic [7:0] rec_r, rec_nxt;

	logic [28:0] frame_vec;
	logic [28:0] mask_vec;
	logic [NUM_FILTERS-1:0] hit;
	logic accept;
	logic [7:0] id_low_rd;

	// bus slave: writes are zero-wait, reads take one wait state so hrdata comes from a flop
	assign addr_phase = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
	assign wr_en = wr_pend_r;
	assign wbyte = hwdata[7:0];
	assign hreadyout = ~rd_pend_r;
	assign hresp = 1'b0;
	assign hrdata = rdata_r;

	// SUBSTITUTE_REMOTE_FLAG is not stored; derived so it cannot disagree with the format flag
	always_comb begin
		id_low_rd = id_low_r;
		id_low_rd[SRR_BIT] = ~id_low_r[EXT_BIT] & copy_r;
	end

	always_comb begin
		rd_pend_nxt = 1'b0;
		wr_pend_nxt = 1'b0;
		addr_nxt = addr_r;
		rdata_nxt = rdata_r;
		if (addr_phase) begin
			addr_nxt = haddr[ADDR_LSB_W-1:0];
			wr_pend_nxt = hwrite;
			rd_pend_nxt = ~hwrite;
		end
		if (rd_pend_r) begin
			rdata_nxt = 32'h0000_0000;
			case (addr_r)
				OFS_CTRL: begin
					rdata_nxt[FULL_BIT] = full_r;
					rdata_nxt[COPY_BIT] = copy_r;
					rdata_nxt[HIT_BIT] = hit_r;
				end
				OFS_ID_HIGH: rdata_nxt[7:0] = id_high_r;
				OFS_ID_LOW: rdata_nxt[7:0] = id_low_rd;
				OFS_EXT_HIGH: rdata_nxt[7:0] = ext_high_r;
				OFS_EXT_LOW: rdata_nxt[7:0] = ext_low_r;
				OFS_LENGTH: rdata_nxt[7:0] = length_r;
				OFS_REC: rdata_nxt[7:0] = rec_r;
				OFS_STATUS: rdata_nxt[PASSIVE_BIT] = error_passive;
				default: begin
					if (addr_r >= OFS_DATA0 && addr_r <= OFS_DATA7 && addr_r[1:0] == 2'h0) begin
						rdata_nxt[7:0] = data_r[3'(addr_r[7:2] - OFS_DATA0[7:2])];
					end else if (addr_r[7:6] == ID_REGION && addr_r[5:4] != 2'h3 && addr_r[1:0] == 2'h0) begin
						case (addr_r[3:2])
							2'h0: rdata_nxt[7:0] = sets_r[addr_r[5:4]].high;
							2'h1: rdata_nxt[7:0] = sets_r[addr_r[5:4]].low;
							2'h2: rdata_nxt[7:0] = sets_r[addr_r[5:4]].ext_high;
							default: rdata_nxt[7:0] = sets_r[addr_r[5:4]].ext_low;
						endcase
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_pend_r <= 1'b0;
			wr_pend_r <= 1'b0;
			addr_r <= 8'h00;
			rdata_r <= 32'h0000_0000;
		end else begin
			rd_pend_r <= rd_pend_nxt;
			wr_pend_r <= wr_pend_nxt;
			addr_r <= addr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// acceptance: both sides laid out as a 29-bit extended vector
	assign frame_vec = rx_frame.ext ? rx_frame.id : {rx_frame.id[10:0], 18'h0_0000};
	assign mask_vec = {sets_r[MASK_IDX].high, sets_r[MASK_IDX].low[7:5], sets_r[MASK_IDX].low[1:0],
		sets_r[MASK_IDX].ext_high, sets_r[MASK_IDX].ext_low} & (rx_frame.ext ? 29'h1FFF_FFFF : 29'h1FFC_0000);

	for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_filter
		logic [28:0] filt_vec;
		assign filt_vec = {sets_r[f].high, sets_r[f].low[7:5], sets_r[f].low[1:0], sets_r[f].ext_high, sets_r[f].ext_low};
		assign hit[f] = (((filt_vec ^ frame_vec) & mask_vec) == 29'h0) && (sets_r[f].low[EXT_BIT] == rx_frame.ext);
	end

	// an occupied buffer drops frames until software releases it
	assign accept = rx_frame.valid && state_r == ST_IDLE && !full_r && (|hit) && rx_frame.length <= MAX_LENGTH;

	always_comb begin
		state_nxt = state_r;
		full_nxt = full_r;
		copy_nxt = copy_r;
		hit_nxt = hit_r;
		id_high_nxt = id_high_r;
		id_low_nxt = id_low_r;
		ext_high_nxt = ext_high_r;
		ext_low_nxt = ext_low_r;
		length_nxt = length_r;
		sets_nxt = sets_r;
		for (int i = 0; i < DATA_BYTES; i++) begin
			data_nxt[i] = data_r[i];
		end
		if (wr_en) begin
			case (addr_r)
				OFS_CTRL: begin
					if (!wbyte[FULL_BIT]) begin
						full_nxt = 1'b0;
					end
				end
				OFS_ID_HIGH: id_high_nxt = wbyte;
				OFS_ID_LOW: id_low_nxt = wbyte & ID_LOW_WMASK;
				OFS_EXT_HIGH: ext_high_nxt = wbyte;
				OFS_EXT_LOW: ext_low_nxt = wbyte;
				OFS_LENGTH: length_nxt = wbyte & LENGTH_WMASK;
				default: begin
					if (addr_r >= OFS_DATA0 && addr_r <= OFS_DATA7 && addr_r[1:0] == 2'h0) begin
						data_nxt[3'(addr_r[7:2] - OFS_DATA0[7:2])] = wbyte;
					end else if (addr_r[7:6] == ID_REGION && addr_r[5:4] != 2'h3 && addr_r[1:0] == 2'h0) begin
						case (addr_r[3:2])
							2'h0: sets_nxt[addr_r[5:4]].high = wbyte;
							2'h1: sets_nxt[addr_r[5:4]].low = wbyte &
								((addr_r[5:4] == 2'(MASK_IDX)) ? MASK_LOW_WMASK : FILTER_LOW_WMASK);
							2'h2: sets_nxt[addr_r[5:4]].ext_high = wbyte;
							default: sets_nxt[addr_r[5:4]].ext_low = wbyte;
						endcase
					end
				end
			endcase
		end
		case (state_r)
			ST_IDLE: begin
				if (accept) begin
					// hardware load wins over a software write in the same cycle
					state_nxt = ST_COMMIT;
					copy_nxt = rx_frame.rtr;
					hit_nxt = ~hit[0];
					id_high_nxt = rx_frame.ext ? rx_frame.id[28:21] : rx_frame.id[10:3];
					id_low_nxt = 8'h00;
					id_low_nxt[7:5] = rx_frame.ext ? rx_frame.id[20:18] : rx_frame.id[2:0];
					id_low_nxt[EXT_BIT] = rx_frame.ext;
					id_low_nxt[1:0] = rx_frame.ext ? rx_frame.id[17:16] : 2'h0;
					ext_high_nxt = rx_frame.ext ? rx_frame.id[15:8] : 8'h00;
					ext_low_nxt = rx_frame.ext ? rx_frame.id[7:0] : 8'h00;
					length_nxt = {1'b0, rx_frame.rtr, 2'h0, rx_frame.length};
					for (int i = 0; i < DATA_BYTES; i++) begin
						// bytes past the length code are cleared so stale data never reads back
						data_nxt[i] = (4'(i) < rx_frame.length) ? rx_frame.data[8*i +: 8] : 8'h00;
					end
				end
			end
			ST_COMMIT: begin
				state_nxt = ST_IDLE;
				full_nxt = 1'b1;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_IDLE;
			full_r <= 1'b0;
			copy_r <= 1'b0;
			hit_r <= 1'b0;
			id_high_r <= 8'h00;
			id_low_r <= 8'h00;
			ext_high_r <= 8'h00;
			ext_low_r <= 8'h00;
			length_r <= 8'h00;
			for (int i = 0; i < DATA_BYTES; i++) begin
				data_r[i] <= 8'h00;
			end
			for (int s = 0; s < NUM_ID_SETS; s++) begin
				sets_r[s] <= '0;
			end
		end else begin
			state_r <= state_nxt;
			full_r <= full_nxt;
			copy_r <= copy_nxt;
			hit_r <= hit_nxt;
			id_high_r <= id_high_nxt;
			id_low_r <= id_low_nxt;
			ext_high_r <= ext_high_nxt;
			ext_low_r <= ext_low_nxt;
			length_r <= length_nxt;
			data_r <= data_nxt;
			sets_r <= sets_nxt;
		end
	end

	// receive error counter: +8 beats +1 beats success; saturates instead of wrapping
	always_comb begin
		rec_nxt = rec_r;
		if (rx_err_large) begin
			rec_nxt = (rec_r > REC_MAX - REC_STEP_LARGE) ? REC_MAX : rec_r + REC_STEP_LARGE;
		end else if (rx_err_small) begin
			rec_nxt = (rec_r == REC_MAX) ? REC_MAX : rec_r + REC_STEP_SMALL;
		end else if (rx_ok) begin
			if (rec_r > REC_PASSIVE_LIMIT) begin
				rec_nxt = REC_RESTORE;
			end else if (rec_r != 8'h00) begin
				rec_nxt = rec_r - REC_STEP_SMALL;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rec_r <= 8'h00;
		end else begin
			rec_r <= rec_nxt;
		end
	end

	// passive only; no bus-off output exists on this counter by design
	assign error_passive = rec_r > REC_PASSIVE_LIMIT;
	assign buffer_full = full_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_FULL_AFTER_STORE: assert property (
		accept |=> !full_r ##1 full_r)
		else $error("full flag not raised two cycles after store");
	AST_ID_HIGH_MAP: assert property (
		accept |=> id_high_r == ($past(rx_frame.ext) ? $past(rx_frame.id[28:21]) : $past(rx_frame.id[10:3])))
		else $error("id high byte mismapped");
	AST_ID_LOW_MAP: assert property (
		accept |=> id_low_r[7:5] == ($past(rx_frame.ext) ? $past(rx_frame.id[20:18]) : $past(rx_frame.id[2:0])))
		else $error("id low bits 7-5 mismapped");
	AST_SRR_VALUE: assert property (
		accept |=> id_low_rd[SRR_BIT] == (!$past(rx_frame.ext) && $past(rx_frame.rtr)))
		else $error("substitute remote flag wrong");
	AST_EXT_FLAG: assert property (
		accept |=> id_low_r[EXT_BIT] == $past(rx_frame.ext) && id_low_r[2] == 1'b0)
		else $error("format flag wrong after store");
	AST_EXT_BYTES: assert property (
		accept && rx_frame.ext |=> {id_low_r[1:0], ext_high_r, ext_low_r} == $past(rx_frame.id[17:0]))
		else $error("extended id bytes mismapped");
	AST_LENGTH_REG: assert property (
		accept |=> length_r == {1'b0, $past(rx_frame.rtr), 2'h0, $past(rx_frame.length)})
		else $error("length register wrong after store");
	AST_INVALID_DROPPED: assert property (
		rx_frame.valid && rx_frame.length > MAX_LENGTH && state_r == ST_IDLE |=> state_r == ST_IDLE)
		else $error("frame with invalid length was stored");
	AST_FULL_STICKY: assert property (
		full_r && !(wr_en && addr_r == OFS_CTRL) |=> full_r)
		else $error("full flag dropped without software clear");
	AST_PASSIVE_ENTRY: assert property (
		rec_r == REC_PASSIVE_LIMIT && rx_err_small |=> error_passive)
		else $error("error passive not entered above 127");
	AST_FILTER_FORMAT: assert property (
		accept |=> sets_r[hit_r].low[EXT_BIT] == $past(rx_frame.ext))
		else $error("filter accepted frame of wrong format");
	AST_DROP_WHEN_FULL: assert property (
		full_r && rx_frame.valid && !wr_en |=> $stable(id_high_r) && $stable(length_r))
		else $error("stored frame overwritten while buffer full");
	AST_STD_EXT_ZERO: assert property (
		accept && !rx_frame.ext |=> ext_high_r == 8'h00 && ext_low_r == 8'h00 && id_low_r[1:0] == 2'h0)
		else $error("standard frame left extended id bits set");
	AST_DATA_ENDS: assert property (
		accept |=> data_r[0] == (($past(rx_frame.length) != 4'h0) ? $past(rx_frame.data[7:0]) : 8'h00) &&
			data_r[DATA_BYTES-1] == (($past(rx_frame.length) == MAX_LENGTH) ? $past(rx_frame.data[63:56]) : 8'h00))
		else $error("first or last data byte stored wrong");
	AST_REC_LARGE_STEP: assert property (
		rx_err_large && rec_r <= REC_MAX - REC_STEP_LARGE |=> rec_r == $past(rec_r) + REC_STEP_LARGE)
		else $error("receive error counter did not step by eight");
	AST_REC_SATURATE: assert property (
		rec_r == REC_MAX && (rx_err_large || rx_err_small) |=> rec_r == REC_MAX)
		else $error("receive error counter wrapped past its top");
	AST_PASSIVE_EXIT: assert property (
		error_passive && rx_ok && !rx_err_small && !rx_err_large |=> !error_passive)
		else $error("error passive kept after good reception");
endmodule

/* File: verification/can_bus_node.sv */
// far-side CAN node model: delivers received frames and error events
`timescale 1ns/10ps
module can_bus_node
	import can_rx_pkg::*;
(
	input wire logic hclk,
	output rx_frame_t rx_frame,
	output logic rx_err_small,
	output logic rx_err_large,
	output logic rx_ok
);
	initial begin
		rx_frame = '0;
		rx_err_small = 1'b0;
		rx_err_large = 1'b0;
		rx_ok = 1'b0;
	end
	// one-cycle pulse; fields then inverted so stale values never pass as a frame
	task automatic send(input logic ext, input logic rtr, input logic [28:0] id, input logic [3:0] len,
		input logic [63:0] d);
		@(posedge hclk);
		rx_frame <= '{1'b1, ext, rtr, id, len, d};
		@(posedge hclk);
		rx_frame <= '{1'b0, ~ext, ~rtr, ~id, ~len, ~d};
	endtask
	// kind 2 large error, 1 small error, 0 good reception
	task automatic events(input int kind, input int n);
		repeat (n) begin
			@(posedge hclk);
			rx_err_large <= (kind == 2);
			rx_err_small <= (kind == 1);
			rx_ok <= (kind == 0);
			@(posedge hclk);
			rx_err_large <= 1'b0;
			rx_err_small <= 1'b0;
			rx_ok <= 1'b0;
		end
	endtask
endmodule

/* File: verification/tb.sv */
// self-checking bench for the CAN receive buffer and filter register block
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module tb;
	import can_rx_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic hready, hreadyout, hresp, error_passive, buffer_full, rx_err_small, rx_err_large, rx_ok;
	logic [31:0] hrdata;
	rx_frame_t rx_frame;
	logic [31:0] q[$];
	logic rd_pend = 1'b0;
	integer seed = 32'h8D8B;
	logic [31:0] exp_rd;
	logic [28:0] ide, ids;
	logic [63:0] d;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	assign hready = hreadyout;
	always #4 hclk = ~hclk;
	can_rx_regs uut(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .rx_frame(rx_frame), .rx_err_small(rx_err_small),
		.rx_err_large(rx_err_large), .rx_ok(rx_ok), .error_passive(error_passive), .buffer_full(buffer_full));
	can_bus_node node(.hclk(hclk), .rx_frame(rx_frame), .rx_err_small(rx_err_small),
		.rx_err_large(rx_err_large), .rx_ok(rx_ok));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			print_verdict();
		end
	end
	// read data phase ends where hreadyout is high again; sampled mid-cycle when settled
	always @(negedge hclk) begin
		if (rd_pend && hreadyout) begin
			// pop once: the macro names its expected value twice
			exp_rd = q.pop_front();
			`CHK("hrdata", exp_rd, hrdata)
			`CHK("hresp", 1'b0, hresp)
			rd_pend = 1'b0;
		end
		if (hsel && htrans[HTRANS_ACTIVE_BIT] && hready && !hwrite)
			rd_pend = 1'b1;
	end
	task automatic waitrdy();
		logic r;
		do begin
			@(negedge hclk);
			r = hready;
			@(posedge hclk);
		end while (!r);
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] dt, input logic [31:0] e);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		if (!wr)
			q.push_back(e);
		waitrdy();
		htrans <= 2'h0;
		hwdata <= dt;
		waitrdy();
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dt);
		ahb(1'b1, a, dt, 32'h0);
	endtask
	function automatic logic [31:0] idv(input logic ext, input logic rtr, input logic [28:0] id);
		if (ext)
			return {id[28:21], id[20:18], 3'b010, id[17:16], id[15:0]};
		return {id[10:3], id[2:0], rtr, 4'h0, 16'h0};
	endfunction
	task automatic setf(input logic [7:0] base, input logic ext, input logic [28:0] id);
		logic [31:0] v;
		v = idv(ext, 1'b0, id);
		for (int i = 0; i < 4; i++)
			wr(base + 8'(4 * i), {24'h0, v[31 - 8 * i -: 8]});
	endtask
	task automatic frame(input logic ext, input logic rtr, input logic [28:0] id, input logic [3:0] len);
		node.send(ext, rtr, id, len, d);
		repeat (2) @(posedge hclk);
		@(negedge hclk);
	endtask
	task automatic chk_buf(input logic ext, input logic rtr, input logic [28:0] id, input logic [3:0] len);
		logic [31:0] v;
		v = idv(ext, rtr, id);
		for (int i = 0; i < 4; i++)
			rd(OFS_ID_HIGH + 8'(4 * i), {24'h0, v[31 - 8 * i -: 8]});
		rd(OFS_LENGTH, {24'h0, 1'b0, rtr, 2'b00, len});
		for (int i = 0; i < DATA_BYTES; i++)
			rd(OFS_DATA0 + 8'(4 * i), (i < len) ? {24'h0, d[8 * i +: 8]} : 32'h0);
	endtask
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd(OFS_REC, 32'h0);
		wr(OFS_REC, 32'hFF);
		rd(OFS_REC, 32'h0);
		rd(OFS_CTRL, 32'h0);
		for (int i = 0; i < 4; i++)
			wr(8'h60 + 8'(4 * i), 32'hFF);
		rd(8'h64, 32'h000000E3);
		wr(8'h54, 32'hFF);
		rd(8'h54, 32'h000000EB);
		ide = 29'($random(seed));
		ids = {18'h0, 11'($random(seed))};
		d = {$random(seed), $random(seed)};
		setf(8'h40, 1'b1, ide);
		setf(8'h50, 1'b0, ids);
		frame(1'b1, 1'b0, ide, 4'h8);
		`CHK("buffer_full", 1'b1, buffer_full)
		chk_buf(1'b1, 1'b0, ide, 4'h8);
		rd(OFS_CTRL, 32'h80);
		// a frame arriving while full must leave the stored one intact
		frame(1'b1, 1'b0, ide, 4'h2);
		rd(OFS_LENGTH, 32'h08);
		wr(OFS_CTRL, 32'h0);
		@(negedge hclk);
		`CHK("buffer_full", 1'b0, buffer_full)
		d = {$random(seed), $random(seed)};
		frame(1'b0, 1'b1, ids, 4'h3);
		chk_buf(1'b0, 1'b1, ids, 4'h3);
		rd(OFS_CTRL, 32'h89);
		wr(OFS_CTRL, 32'h0);
		frame(1'b1, 1'b0, ide, 4'h9);
		`CHK("buffer_full", 1'b0, buffer_full)
		frame(1'b0, 1'b0, ids ^ 29'h1, 4'h2);
		`CHK("buffer_full", 1'b0, buffer_full)
		frame(1'b1, 1'b0, ids, 4'h2);
		`CHK("buffer_full", 1'b0, buffer_full)
		frame(1'b1, 1'b0, ide ^ 29'h10000, 4'h2);
		`CHK("buffer_full", 1'b0, buffer_full)
		node.events(2, 15);
		@(negedge hclk);
		`CHK("error_passive", 1'b0, error_passive)
		node.events(1, 8);
		@(negedge hclk);
		`CHK("error_passive", 1'b1, error_passive)
		rd(OFS_REC, 32'h80);
		rd(OFS_STATUS, 32'h1);
		node.events(0, 1);
		rd(OFS_REC, {24'h0, REC_RESTORE});
		`CHK("error_passive", 1'b0, error_passive)
		node.events(2, 20);
		rd(OFS_REC, 32'hFF);
		// second reset in mid-run: a saturated counter must fall back to zero
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd(OFS_REC, 32'h0);
		`CHK("error_passive", 1'b0, error_passive)
		print_verdict();
	end
endmodule
